// *** inc/ocfr_consts.vh ***
`ifndef OCFR_CONSTS_VH
`define OCFR_CONSTS_VH

// command code of the response byte
`define OCFR_CMD_RESPONSE 8'h47
// response byte reset value (ignore fault, no retry, one unit)
`define OCFR_RESPONSE_RESET 8'h00
// field positions
`define OCFR_RESP_HI 7
`define OCFR_RESP_LO 6
`define OCFR_RETRY_HI 5
`define OCFR_RETRY_LO 3
`define OCFR_DELAY_HI 2
`define OCFR_DELAY_LO 0
// response field encodings
`define OCFR_RESP_IGNORE 2'h0
`define OCFR_RESP_COND_CC 2'h1
`define OCFR_RESP_SHUTDOWN 2'h2
`define OCFR_RESP_DELAY_CC 2'h3
// retry field encodings
`define OCFR_RETRY_NONE 3'h0
`define OCFR_RETRY_FOREVER 3'h7

`endif

// *** rtl/ocfr_delay_timer.v ***
`timescale 1ns/1ps
// times 2^code units, each unit being unit_cycles clock cycles
module ocfr_delay_timer #(
	parameter UNIT_W = 16
) (
	ref_clk,
	rst,
	ce,
	start,
	code,
	unit_cycles,
	busy,
	done
);
	input wire ref_clk;
	input wire rst;
	input wire ce;
	input wire start;
	input wire [2:0] code;
	input wire [UNIT_W-1:0] unit_cycles;
	output reg busy;
	output reg done;

	reg [UNIT_W-1:0] tick_reg;
	reg [7:0] unit_reg;
	reg [7:0] units_m1;
	wire unit_end;

	always @*
	begin
		units_m1 = (8'h01 << code) - 8'h01;
	end

	// done is raised during the last cycle, so a user acting on it at the
	// next edge sees exactly 2^code units from the start edge, not one more
	always @*
	begin
		done = busy && unit_end && (unit_reg == units_m1);
	end

	// a zero unit length is treated as one cycle so the timer cannot hang
	assign unit_end = (tick_reg + {{(UNIT_W-1){1'b0}}, 1'b1} >= unit_cycles);

	always @(posedge ref_clk)
	begin
		if (rst)
		begin
			busy <= 1'b0;
			tick_reg <= {UNIT_W{1'b0}};
			unit_reg <= 8'h00;
		end
		else if (ce)
		begin
			if (start)
			begin
				busy <= 1'b1;
				tick_reg <= {UNIT_W{1'b0}};
				unit_reg <= 8'h00;
			end
			else if (busy)
			begin
				if (unit_end)
				begin
					tick_reg <= {UNIT_W{1'b0}};
					if (unit_reg == units_m1)
					begin
						busy <= 1'b0;
					end
					else
						unit_reg <= unit_reg + 8'h01;
				end
				else
					tick_reg <= tick_reg + {{(UNIT_W-1){1'b0}}, 1'b1};
			end
		end
	end
endmodule // ocfr_delay_timer

// *** rtl/ocfr_ctrl.v ***
`timescale 1ns/1ps
`include "ocfr_consts.vh"

module ocfr_ctrl #(
	parameter UNIT_W = 16
) (
	ref_clk,
	rst,
	ce,
	cmd_code,
	cmd_data,
	cmd_wr,
	time_unit_cycles,
	run_cmd,
	oc_detect,
	lv_detect,
	other_fault,
	fault_clear,
	response_rdata,
	output_on,
	current_limit,
	oc_fault_flag,
	fault_notify,
	latched_off,
	attempts_used
);
	input wire ref_clk;
	input wire rst;
	input wire ce;
	input wire [7:0] cmd_code;
	input wire [7:0] cmd_data;
	input wire cmd_wr;
	input wire [UNIT_W-1:0] time_unit_cycles;
	input wire run_cmd;
	input wire oc_detect;
	input wire lv_detect;
	input wire other_fault;
	input wire fault_clear;
	output reg [7:0] response_rdata;
	output reg output_on;
	output reg current_limit;
	output reg oc_fault_flag;
	output reg fault_notify;
	output reg latched_off;
	output reg [2:0] attempts_used;

	localparam ST_OFF = 3'h0;
	localparam ST_RUN = 3'h1;
	localparam ST_HOLD = 3'h2;
	localparam ST_WAIT = 3'h3;
	localparam ST_TRY = 3'h4;
	localparam ST_LATCH = 3'h5;

	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg [2:0] attempts_next;
	reg timer_start;
	reg fault_event;
	wire timer_busy;
	wire timer_done;
	wire [1:0] resp_mode;
	wire [2:0] retry_code;
	wire [2:0] delay_code;
	wire trip;
	wire may_retry;

	assign resp_mode = response_rdata[`OCFR_RESP_HI:`OCFR_RESP_LO];
	assign retry_code = response_rdata[`OCFR_RETRY_HI:`OCFR_RETRY_LO];
	assign delay_code = response_rdata[`OCFR_DELAY_HI:`OCFR_DELAY_LO];

	// fault that forces an immediate shutdown under the current response mode
	assign trip = oc_detect && ((resp_mode == `OCFR_RESP_SHUTDOWN) ||
		(resp_mode == `OCFR_RESP_COND_CC && lv_detect));

	// retry budget: forever, or attempts still below the programmed count
	assign may_retry = (retry_code == `OCFR_RETRY_FOREVER) ||
		(attempts_used < retry_code);

	// one timer serves both the limiting delay and the retry spacing
	ocfr_delay_timer #(
		.UNIT_W(UNIT_W)
	) u_timer (
		.ref_clk(ref_clk),
		.rst(rst),
		.ce(ce),
		.start(timer_start),
		.code(delay_code),
		.unit_cycles(time_unit_cycles),
		.busy(timer_busy),
		.done(timer_done)
	);

	always @*
	begin
		state_next = state_reg;
		attempts_next = attempts_used;
		timer_start = 1'b0;
		fault_event = 1'b0;
		if (!run_cmd || other_fault)
		begin
			// commanded off or another fault ends any retry sequence
			state_next = ST_OFF;
			attempts_next = 3'h0;
		end
		else
		begin
			case (state_reg)
				ST_OFF:
				begin
					state_next = ST_RUN;
				end
				ST_RUN:
				begin
					fault_event = oc_detect;
					if (trip)
					begin
						if (retry_code == `OCFR_RETRY_NONE)
							state_next = ST_LATCH;
						else
						begin
							state_next = ST_WAIT;
							timer_start = 1'b1;
						end
					end
					else if (oc_detect && resp_mode == `OCFR_RESP_DELAY_CC)
					begin
						state_next = ST_HOLD;
						timer_start = 1'b1;
					end
				end
				ST_HOLD:
				begin
					if (!oc_detect)
						state_next = ST_RUN;
					else if (timer_done)
					begin
						if (retry_code == `OCFR_RETRY_NONE)
							state_next = ST_LATCH;
						else
						begin
							state_next = ST_WAIT;
							timer_start = 1'b1;
						end
					end
				end
				ST_WAIT:
				begin
					// the timer was started on entry, or at the attempt start if TRY tripped; an idle
					// timer covers a trip that landed on the timer's last cycle
					if (timer_done || !timer_busy)
					begin
						if (may_retry)
						begin
							state_next = ST_TRY;
							timer_start = 1'b1;
							if (retry_code != `OCFR_RETRY_FOREVER)
								attempts_next = attempts_used + 3'h1;
						end
						else
							state_next = ST_LATCH;
					end
				end
				ST_TRY:
				begin
					fault_event = oc_detect;
					if (trip)
						state_next = ST_WAIT;
					else if (timer_done)
					begin
						if (oc_detect && resp_mode == `OCFR_RESP_DELAY_CC)
						begin
							state_next = ST_WAIT;
							timer_start = 1'b1;
						end
						else
						begin
							state_next = ST_RUN;
							attempts_next = 3'h0;
						end
					end
				end
				ST_LATCH:
				begin
					if (fault_clear)
					begin
						state_next = ST_RUN;
						attempts_next = 3'h0;
					end
				end
				default:
				begin
					state_next = ST_OFF;
				end
			endcase
		end
	end

	always @(posedge ref_clk)
	begin
		if (rst)
		begin
			state_reg <= ST_OFF;
			response_rdata <= `OCFR_RESPONSE_RESET;
			output_on <= 1'b0;
			current_limit <= 1'b0;
			oc_fault_flag <= 1'b0;
			fault_notify <= 1'b0;
			latched_off <= 1'b0;
			attempts_used <= 3'h0;
		end
		else if (ce)
		begin
			if (cmd_wr && cmd_code == `OCFR_CMD_RESPONSE)
				response_rdata <= cmd_data;
			state_reg <= state_next;
			attempts_used <= attempts_next;
			output_on <= (state_next == ST_RUN) || (state_next == ST_HOLD) ||
				(state_next == ST_TRY);
			latched_off <= (state_next == ST_LATCH);
			// clamp whenever running with overcurrent, except when shutdown wins
			current_limit <= oc_detect && !trip && ((state_next == ST_RUN) ||
				(state_next == ST_HOLD) || (state_next == ST_TRY));
			fault_notify <= fault_event && !oc_fault_flag;
			// a new fault in the clearing cycle keeps the flag set
			if (fault_event)
				oc_fault_flag <= 1'b1;
			else if (fault_clear)
				oc_fault_flag <= 1'b0;
		end
	end
endmodule // ocfr_ctrl

// *** testbench/ocfr_props.sv ***
`timescale 1ns/1ps
module ocfr_props #(
	parameter UNIT_W = 16
) (
	input wire ref_clk,
	input wire rst,
	input wire ce,
	input wire cmd_wr,
	input wire run_cmd,
	input wire oc_detect,
	input wire lv_detect,
	input wire other_fault,
	input wire fault_clear,
	input wire [7:0] cmd_code,
	input wire [7:0] cmd_data,
	input wire [7:0] response_rdata,
	input wire [UNIT_W-1:0] time_unit_cycles,
	input wire output_on,
	input wire current_limit,
	input wire oc_fault_flag,
	input wire fault_notify,
	input wire latched_off,
	input wire [2:0] attempts_used
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	wire [1:0] resp = response_rdata[7:6];
	wire [2:0] rtry = response_rdata[5:3];
	// a write in flight may change the mode, so mode checks skip that edge
	wire go = ce && run_cmd && !other_fault && !cmd_wr;
	wr_echo_a: assert property (
		ce && cmd_wr && cmd_code == 8'h47 |=> response_rdata == $past(cmd_data))
		else $error("readback wrong");
	cmd_off_a: assert property (
		ce && (!run_cmd || other_fault) |=> !output_on && attempts_used == 3'h0)
		else $error("output not off");
	// a low enable freezes the pulse, so only a freshly computed one is judged
	notify_edge_a: assert property (
		fault_notify && $past(ce) |-> oc_fault_flag && !$past(oc_fault_flag))
		else $error("stray notify");
	notify_once_a: assert property (
		fault_notify && ce |=> !fault_notify) else $error("notify too long");
	ignore_clamp_a: assert property (
		go && resp == 2'h0 && output_on |=> output_on && current_limit == $past(oc_detect))
		else $error("clamp mode broken");
	trip_off_a: assert property (
		go && output_on && oc_detect && (resp == 2'h2 || resp == 2'h1 && lv_detect)
		|=> !output_on) else $error("no shutdown");
	latch_hold_a: assert property (
		go && latched_off && !fault_clear |=> latched_off && !output_on)
		else $error("latch lost");
	attempt_cap_a: assert property (
		rtry != 3'h7 |-> attempts_used <= rtry) else $error("too many attempts");
	endless_a: assert property (
		rtry == 3'h7 |-> attempts_used == 3'h0) else $error("counted in endless mode");
endmodule // ocfr_props

bind ocfr_ctrl ocfr_props #(
	.UNIT_W(UNIT_W)
) i_props (
	.ref_clk(ref_clk),
	.rst(rst),
	.ce(ce),
	.cmd_wr(cmd_wr),
	.run_cmd(run_cmd),
	.oc_detect(oc_detect),
	.lv_detect(lv_detect),
	.other_fault(other_fault),
	.fault_clear(fault_clear),
	.cmd_code(cmd_code),
	.cmd_data(cmd_data),
	.response_rdata(response_rdata),
	.time_unit_cycles(time_unit_cycles),
	.output_on(output_on),
	.current_limit(current_limit),
	.oc_fault_flag(oc_fault_flag),
	.fault_notify(fault_notify),
	.latched_off(latched_off),
	.attempts_used(attempts_used)
);

// *** testbench/ocfr_load.sv ***
`timescale 1ns/1ps
// power stage stand-in: no current and no sag while the output is off
module ocfr_load (
	input wire output_on,
	input wire overload,
	input wire sag,
	output wire oc_detect,
	output wire lv_detect
);
	assign oc_detect = output_on & overload;
	assign lv_detect = output_on & sag;
endmodule // ocfr_load

// *** testbench/ocfr_ctrl_tb_top.sv ***
`timescale 1ns/1ps
module ocfr_ctrl_tb_top;
	reg ref_clk = 0;
	reg rst = 1;
	reg ce = 1;
	reg cmd_wr = 0;
	reg run_cmd = 0;
	reg fclr = 0;
	reg ovl = 0;
	reg sag = 0;
	reg p = 0;
	reg oth = 0;
	reg [15:0] unit = 16'h0002;
	reg [7:0] code = 8'h00;
	reg [7:0] data = 8'h00;
	reg [7:0] n, k, t;
	wire [7:0] rd;
	wire [2:0] att;
	wire on, lim, flg, ntf, lat, oc, lv;
	integer errors = 0;
	integer num_checks = 0;
	always #10 ref_clk = ~ref_clk;
	ocfr_load i_load (.output_on(on), .overload(ovl), .sag(sag), .oc_detect(oc), .lv_detect(lv));
	ocfr_ctrl #(.UNIT_W(16)) i_dut (.ref_clk(ref_clk), .rst(rst), .ce(ce), .cmd_code(code),
		.cmd_data(data), .cmd_wr(cmd_wr), .time_unit_cycles(unit), .run_cmd(run_cmd),
		.oc_detect(oc), .lv_detect(lv), .other_fault(oth), .fault_clear(fclr),
		.response_rdata(rd), .output_on(on), .current_limit(lim), .oc_fault_flag(flg),
		.fault_notify(ntf), .latched_off(lat), .attempts_used(att));
	task chk(input [7:0] got, input [7:0] exp);
	begin
		num_checks = num_checks + 1;
		if (got !== exp)
		begin
			errors = errors + 1;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	end
	endtask
	// outputs are read at the edge, before the design's own updates land
	task tick(input integer c);
		repeat (c) @(posedge ref_clk);
	endtask
	task cfg(input [7:0] v);
	begin
		run_cmd <= 0;
		ovl <= 0;
		sag <= 0;
		code <= 8'h47;
		data <= v;
		cmd_wr <= 1;
		// clearing with the write starts every scenario with a clean flag
		fclr <= 1;
		tick(1);
		cmd_wr <= 0;
		fclr <= 0;
		tick(1);
		run_cmd <= 1;
		tick(3);
	end
	endtask
	task s_reg;
	begin
		code <= 8'h46;
		data <= 8'hA5;
		cmd_wr <= 1;
		tick(1);
		code <= 8'h47;
		ce <= 0;
		tick(1);
		cmd_wr <= 0;
		ce <= 1;
		tick(2);
		chk(rd, 8'h00);
	end
	endtask
	task s_ignore;
	begin
		cfg(8'h07);
		ovl <= 1;
		tick(20);
		chk({5'h0, on, lim, lat}, 8'h06);
	end
	endtask
	task s_cond;
	begin
		cfg(8'h48);
		chk(rd, 8'h48);
		ovl <= 1;
		tick(2);
		chk({7'h0, ntf}, 8'h01);
		tick(8);
		chk({5'h0, on, lim, flg}, 8'h07);
		sag <= 1;
		tick(30);
		chk({6'h0, on, lat}, 8'h01);
	end
	endtask
	// limiting starts one edge after the overload and must last exactly 8 cycles
	task s_delay;
	begin
		cfg(8'hC2);
		ovl <= 1;
		tick(3);
		ovl <= 0;
		tick(15);
		chk({6'h0, on, lat}, 8'h02);
		ovl <= 1;
		tick(8);
		chk({6'h0, on, lim}, 8'h03);
		tick(2);
		chk({6'h0, on, lat}, 8'h01);
	end
	endtask
	// one failed attempt, then the overload is gone before the second one
	task s_recover;
	begin
		cfg(8'h98);
		ovl <= 1;
		tick(4);
		ovl <= 0;
		tick(2);
		chk({4'h0, on, att}, 8'h0A);
		tick(4);
		chk({3'h0, on, lat, att}, 8'h10);
	end
	endtask
	task s_stop;
	begin
		cfg(8'hB8);
		ovl <= 1;
		tick(10);
		chk({7'h0, flg}, 8'h01);
		oth <= 1;
		tick(3);
		chk({5'h0, on, lat, lim}, 8'h00);
		tick(10);
		chk({4'h0, on, att}, 8'h00);
		oth <= 0;
		ovl <= 0;
		tick(4);
		chk({4'h0, on, att}, 8'h08);
	end
	endtask
	task s_retry(input [2:0] r, input [2:0] d);
	begin
		cfg({2'h2, r, d});
		ovl <= 1;
		n = 0;
		k = 0;
		t = 0;
		p = 1;
		while (!lat && k < 200)
		begin
			tick(1);
			k = k + 1;
			if (on && !p)
			begin
				if (n > 0)
					chk(k - t, unit[7:0] << d);
				t = k;
				n = n + 1;
			end
			p = on;
		end
		if (r == 3'h7)
			chk({7'h0, n > 40}, 8'h01);
		else
			chk(n, {5'h0, r});
		chk({7'h0, flg}, 8'h01);
		ovl <= 0;
		fclr <= 1;
		tick(1);
		fclr <= 0;
		tick(12);
		chk({4'h0, on, att}, 8'h08);
	end
	endtask
	task close_out;
	begin
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	end
	endtask
	initial
	begin
		tick(4);
		rst <= 0;
		s_reg;
		s_ignore;
		s_cond;
		s_delay;
		s_recover;
		s_stop;
		s_retry(3'h0, 3'h0);
		s_retry(3'h1, 3'h1);
		s_retry(3'h6, 3'h0);
		// a different base unit shows the spacing follows the unit input
		unit <= 16'h0003;
		s_retry(3'h7, 3'h0);
		close_out;
	end
	initial
	begin
		repeat (5000) @(posedge ref_clk);
		errors = errors + 1;
		close_out;
	end
endmodule // ocfr_ctrl_tb_top
